// [testbench/tb.sv]
// Self-checking bench for the trap unit: AXI4-Lite register access,
// interrupt selection, bus fault NMI and debug masking.
// Assumes the far-side model drives the interrupt lines and data responses.
`timescale 1ns/1ps
module tb
  import tiu_pkg::*;
;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [31:0] irq_pins;
  logic [31:0] line_req = 32'h0;
  logic fault_req = 1'h0;
  logic fault_store = 1'h0;
  tiu_core_t core = '0;
  tiu_exc_t exc = '0;
  tiu_dresp_t dresp;
  logic trap_slot = 1'h0;
  logic halt_issue, trap_take, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [31:0] trap_pc, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr = 8'h0;
  logic [7:0] s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  int failures = 0;
  int checks_done = 0;
  logic halt_adv;

  always #50 clk = ~clk;

  tiu_trap_unit i_dut (.clk, .sys_rst, .irq_pins, .core, .exc, .dresp, .trap_slot,
    .halt_issue, .trap_take, .trap_pc, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tiu_far_model i_far (.clk, .line_req, .fault_req, .fault_store, .irq_pins, .dresp);
  // Second copy in advanced mode sees the same lines and must ignore them
  tiu_trap_unit #(.ADV_MODE(1'b1)) i_dut_adv (.clk, .sys_rst, .irq_pins, .core, .exc, .dresp,
    .trap_slot, .halt_issue(halt_adv), .trap_take(), .trap_pc(), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready);

  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic hang(input bit expired);
    if (expired)
    begin
      failures++;
      test_done;
    end
  endtask : hang

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit ok;
    n = 0;
    ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (n < 50)
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'h1)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1)
        s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1)
      begin
        ok = 1'b1;
        break;
      end
    end
    s_axi_bready <= 1'h0;
    hang(!ok);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ok;
    n = 0;
    ok = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (n < 50)
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'h1)
        s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1)
      begin
        ok = 1'b1;
        break;
      end
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    hang(!ok);
  endtask : axi_rd

  // Bounded watch for a trap; a miss leaves hit low
  task automatic trap_wait(input int lim, output logic hit, output logic [31:0] pc);
    hit = 1'h0;
    pc = 32'h0;
    repeat (lim)
    begin
      @(posedge clk);
      if (trap_take === 1'h1)
      begin
        hit = 1'h1;
        pc = trap_pc;
        break;
      end
    end
  endtask : trap_wait

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    logic hit;
    axi_rd(TIU_OFS_MSTATUS, d, r);
    check("mstatus reset", d, TIU_RST_MSTATUS);
    axi_rd(TIU_OFS_MIE, d, r);
    check("mie reset", d, TIU_RST_MIE);
    line_req <= 32'h0000_0800;
    trap_slot <= 1'h1;
    trap_wait(20, hit, d);
    check("trap while disabled", {31'h0, hit}, 32'h0);
    axi_wr(TIU_OFS_MIE, 32'h0000_0800);
    trap_wait(20, hit, d);
    check("trap without global", {31'h0, hit}, 32'h0);
    trap_slot <= 1'h0;
    line_req <= 32'h0;
    axi_rd(8'h40, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, TIU_RESP_SLVERR});
    $display("test reset done");
  endtask : t_reset

  task automatic t_prio;
    logic [31:0] d;
    logic [1:0] r;
    logic hit;
    core.pc <= 32'h0000_1234;
    axi_wr(TIU_OFS_MTVEC, 32'h0000_0100);
    axi_wr(TIU_OFS_MIE, 32'h0000_0088);
    axi_wr(TIU_OFS_MSTATUS, 32'h0000_0008);
    line_req <= 32'h0000_0088;
    repeat (10) @(posedge clk);
    check("halt issue", {31'h0, halt_issue}, 32'h1);
    check("adv lines ignored", {31'h0, halt_adv}, 32'h0);
    trap_slot <= 1'h1;
    trap_wait(10, hit, d);
    trap_slot <= 1'h0;
    check("trap taken", {31'h0, hit}, 32'h1);
    check("direct target", d, 32'h0000_0100);
    axi_rd(TIU_OFS_MCAUSE, d, r);
    check("mcause prio", d, {1'h1, 20'h0, TIU_CODE_MSI});
    axi_rd(TIU_OFS_MSTATUS, d, r);
    check("mstatus entry", d, 32'h0000_0080);
    axi_rd(TIU_OFS_MEPC, d, r);
    check("mepc entry", d, 32'h0000_1234);
    line_req <= 32'h0;
    core.mret <= 1'h1;
    @(posedge clk);
    core.mret <= 1'h0;
    axi_rd(TIU_OFS_MSTATUS, d, r);
    check("mstatus return", d, 32'h0000_0088);
    $display("test priority done");
  endtask : t_prio

  task automatic t_nmi;
    logic [31:0] d;
    logic [1:0] r;
    logic hit;
    core.debug_mode <= 1'h1;
    axi_wr(TIU_OFS_MSTATUS, 32'h0);
    fault_store <= 1'h1;
    fault_req <= 1'h1;
    @(posedge clk);
    fault_req <= 1'h0;
    repeat (3) @(posedge clk);
    fault_store <= 1'h0;
    fault_req <= 1'h1;
    @(posedge clk);
    fault_req <= 1'h0;
    trap_slot <= 1'h1;
    trap_wait(10, hit, d);
    check("nmi in debug", {31'h0, hit}, 32'h0);
    axi_rd(TIU_OFS_DCSR, d, r);
    check("nmi pending flag", d, 32'h0000_0008);
    core.debug_mode <= 1'h0;
    core.single_step <= 1'h1;
    trap_wait(6, hit, d);
    check("nmi in step", {31'h0, hit}, 32'h0);
    core.single_step <= 1'h0;
    trap_wait(3, hit, d);
    trap_slot <= 1'h0;
    check("nmi after debug", {31'h0, hit}, 32'h1);
    axi_rd(TIU_OFS_MCAUSE, d, r);
    check("mcause nmi", d, {1'h1, 20'h0, TIU_CODE_NMI_STORE});
    axi_rd(TIU_OFS_MSTATUS, d, r);
    check("mstatus nmi", d, 32'h0);
    axi_rd(TIU_OFS_DCSR, d, r);
    check("dcsr outside debug", {30'h0, r}, {30'h0, TIU_RESP_SLVERR});
    $display("test nmi done");
  endtask : t_nmi

  task automatic t_dbg;
    logic [31:0] d;
    logic [1:0] r;
    logic hit;
    core.debug_mode <= 1'h1;
    axi_wr(TIU_OFS_MTVEC, 32'h0000_0101);
    axi_wr(TIU_OFS_MIE, 32'h0001_0000);
    axi_wr(TIU_OFS_MSTATUS, 32'h0000_0008);
    line_req <= 32'h0001_0000;
    trap_slot <= 1'h1;
    trap_wait(12, hit, d);
    check("irq in debug", {31'h0, hit}, 32'h0);
    core.debug_mode <= 1'h0;
    trap_wait(6, hit, d);
    trap_slot <= 1'h0;
    line_req <= 32'h0;
    check("fast irq taken", {31'h0, hit}, 32'h1);
    check("vectored target", d, 32'h0000_0140);
    axi_rd(TIU_OFS_MCAUSE, d, r);
    check("mcause fast", d, 32'h8000_0010);
    $display("test debug done");
  endtask : t_dbg

  // Several flags at once; the table vector stays vectored, exceptions use the base
  task automatic t_exc;
    logic [31:0] d;
    logic [1:0] r;
    logic hit;
    tiu_exc_t cases [5] = '{8'h9F, 8'hB0, 8'hE0, 8'h8D, 8'h83};
    logic [10:0] codes [5] = '{TIU_EXC_ILLEGAL, TIU_EXC_INSTR_BUS, TIU_EXC_INSTR_ACCESS,
      TIU_EXC_ECALL, TIU_EXC_STORE_ACCESS};
    for (int i = 0; i < 5; i++)
    begin
      exc <= cases[i];
      trap_slot <= 1'h1;
      trap_wait(4, hit, d);
      trap_slot <= 1'h0;
      exc <= '0;
      check("exc taken", {31'h0, hit}, 32'h1);
      check("exc target", d, 32'h0000_0100);
      axi_rd(TIU_OFS_MCAUSE, d, r);
      check("exc cause", d, {21'h0, codes[i]});
    end
    exc <= 8'h40;
    trap_slot <= 1'h1;
    trap_wait(4, hit, d);
    trap_slot <= 1'h0;
    exc <= '0;
    check("fetch fault not executed", {31'h0, hit}, 32'h0);
    $display("test exception done");
  endtask : t_exc

  initial
  begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (2) @(posedge clk);
    t_reset;
    t_prio;
    t_nmi;
    t_dbg;
    t_exc;
    test_done;
  end
endmodule : tb

// [testbench/tiu_far_model.sv]
// Far-side model: peripheral interrupt sources and data bus responder.
// Assumes the bench commands line levels and one-cycle fault events.
`timescale 1ns/1ps
module tiu_far_model
  import tiu_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] line_req,
  input wire logic fault_req,
  input wire logic fault_store,
  output logic [31:0] irq_pins,
  output tiu_dresp_t dresp
);
  logic idle_ff = 1'h0;
  always @(posedge clk)
  begin
    // Lines follow the bench-commanded levels one cycle later
    irq_pins <= line_req;
    idle_ff <= ~idle_ff;
    dresp.rvalid <= fault_req;
    // Outside a response the qualifiers wander, never a stale value
    dresp.err <= fault_req | idle_ff;
    dresp.is_store <= fault_req ? fault_store : idle_ff;
  end
endmodule : tiu_far_model

// [verilog/tiu_nmi_latch.sv]
// Data bus fault latch feeding the imprecise NMI.
// Assumes data bus responses are synchronous to clk.
`timescale 1ns/1ps
module tiu_nmi_latch
  import tiu_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire tiu_dresp_t dresp,
  input wire logic nmi_taken,
  output logic pending,
  output logic is_store
);
  logic pend_ff, store_ff;
  logic nxt_pend, nxt_store;
  logic fault;

  assign fault = dresp.rvalid & dresp.err;

  always_comb
  begin
    nxt_pend = pend_ff;
    nxt_store = store_ff;
    if (nmi_taken)
    begin
      nxt_pend = 1'b0;
    end
    // First fault wins; a fault in the entry cycle is latched anew
    if (fault && (!pend_ff || nmi_taken))
    begin
      nxt_pend = 1'b1;
      nxt_store = dresp.is_store;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pend_ff <= 1'b0;
      store_ff <= 1'b0;
    end
    else
    begin
      pend_ff <= nxt_pend;
      store_ff <= nxt_store;
    end
  end

  assign pending = pend_ff;
  assign is_store = store_ff;

  a_nmi_first_kept: assert property (@(posedge clk) disable iff (sys_rst)
    pend_ff && !nmi_taken |=> pend_ff && store_ff == $past(store_ff))
    else $error("latched fault overwritten while pending");
endmodule : tiu_nmi_latch

// [verilog/tiu_pkg.sv]
// Package for the trap and interrupt unit: cause codes, CSR bit positions,
// register map of the AXI4-Lite slave and carrier structs.
// Assumes a 32-bit machine-mode core clocked at 10 MHz.
package tiu_pkg;
  localparam int TIU_XLEN = 32;
  localparam int TIU_ADV_ID_WIDTH = 6;
  // Cause codes
  localparam logic [10:0] TIU_CODE_MSI = 11'h003;
  localparam logic [10:0] TIU_CODE_MTI = 11'h007;
  localparam logic [10:0] TIU_CODE_MEI = 11'h00B;
  localparam logic [10:0] TIU_CODE_NMI_LOAD = 11'h400;
  localparam logic [10:0] TIU_CODE_NMI_STORE = 11'h401;
  localparam logic [10:0] TIU_EXC_INSTR_ACCESS = 11'h001;
  localparam logic [10:0] TIU_EXC_ILLEGAL = 11'h002;
  localparam logic [10:0] TIU_EXC_BREAK = 11'h003;
  localparam logic [10:0] TIU_EXC_LOAD_ACCESS = 11'h005;
  localparam logic [10:0] TIU_EXC_STORE_ACCESS = 11'h007;
  localparam logic [10:0] TIU_EXC_ECALL = 11'h00B;
  localparam logic [10:0] TIU_EXC_INSTR_BUS = 11'h030;
  localparam int TIU_CAUSE_IRQ_BIT = 31;
  localparam int TIU_IRQ_MSI = 3;
  localparam int TIU_IRQ_MTI = 7;
  localparam int TIU_IRQ_MEI = 11;
  localparam int TIU_FAST_LO = 16;
  localparam int TIU_FAST_HI = 31;
  // mstatus fields
  localparam int TIU_MSTATUS_MIE = 3;
  localparam int TIU_MSTATUS_MPIE = 7;
  // Debug control fields
  localparam int TIU_DCSR_NMIP = 3;
  localparam int TIU_DCSR_STEP = 2;
  localparam int TIU_DCSR_STEP_INTERRUPT_ENABLE = 11;
  // Valid interrupt lines in basic mode
  localparam logic [31:0] TIU_IRQ_VALID_MASK = 32'hFFFF_0888;
  // mtvec fields
  localparam logic [31:0] TIU_MTVEC_BASE_MASK = 32'hFFFF_FF00;
  localparam logic [31:0] TIU_RST_MTVEC = 32'h0000_0000;
  localparam logic [31:0] TIU_RST_MIE = 32'h0000_0000;
  localparam logic [31:0] TIU_RST_MSTATUS = 32'h0000_0000;
  // Register byte offsets
  localparam logic [7:0] TIU_OFS_MSTATUS = 8'h00;
  localparam logic [7:0] TIU_OFS_MIE = 8'h04;
  localparam logic [7:0] TIU_OFS_MIP = 8'h08;
  localparam logic [7:0] TIU_OFS_MTVEC = 8'h0C;
  localparam logic [7:0] TIU_OFS_MEPC = 8'h10;
  localparam logic [7:0] TIU_OFS_MCAUSE = 8'h14;
  localparam logic [7:0] TIU_OFS_DCSR = 8'h18;
  localparam logic [7:0] TIU_OFS_TRAPPC = 8'h1C;
  localparam logic [1:0] TIU_RESP_OKAY = 2'h0;
  localparam logic [1:0] TIU_RESP_SLVERR = 2'h2;

  // Core-side per-cycle status
  typedef struct packed {
    logic debug_mode;
    logic single_step;
    logic mret;
    logic [31:0] pc;
  } tiu_core_t;

  // Synchronous exception flags of the instruction in the trap slot
  typedef struct packed {
    logic valid;
    logic instr_access;
    logic instr_bus;
    logic illegal;
    logic ecall;
    logic ebreak;
    logic store_access;
    logic load_access;
  } tiu_exc_t;

  // Data bus response
  typedef struct packed {
    logic rvalid;
    logic err;
    logic is_store;
  } tiu_dresp_t;
endpackage : tiu_pkg

// [verilog/tiu_sync3.sv]
// Three-flop synchroniser for a vector of pins.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/1ps
module tiu_sync3
  import tiu_pkg::*;
#(
  parameter int W = 32
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  // A bit changes only once the second and third stage agree
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      nxt_out[i] = (s2_ff[i] == s3_ff[i]) ? s2_ff[i] : out_ff[i];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end
    else
    begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;
endmodule : tiu_sync3

// [verilog/tiu_trap_unit.sv]
// Trap and interrupt unit: basic-mode interrupt selection, bus fault NMI,
// synchronous exception priority, trap CSRs and an AXI4-Lite slave.
// Assumes the pipeline retires in order and asks via trap_slot when a trap
// may be taken; exception flags are sampled only for an instruction that
// reaches execution.
`timescale 1ns/1ps
module tiu_trap_unit
  import tiu_pkg::*;
#(
  parameter bit ADV_MODE = 1'b0,
  parameter int ADV_ID_WIDTH = TIU_ADV_ID_WIDTH
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] irq_pins,
  input wire tiu_core_t core,
  input wire tiu_exc_t exc,
  input wire tiu_dresp_t dresp,
  input wire logic trap_slot,
  output logic halt_issue,
  output logic trap_take,
  output logic [31:0] trap_pc,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // Advanced mode protocol is outside this unit; check the width range only
  a_id_width_range: assert property (@(posedge clk) ADV_ID_WIDTH >= 6 && ADV_ID_WIDTH <= 10)
    else $error("advanced id width out of range");

  logic [31:0] irq_sync;
  logic nmi_pend, nmi_store;
  logic [31:0] mstatus_ff, mie_ff, mtvec_ff, mepc_ff, mcause_ff, dcsr_ff;
  logic [31:0] nxt_mstatus, nxt_mie, nxt_mtvec, nxt_mepc, nxt_mcause, nxt_dcsr;
  logic take_ff, halt_ff;
  logic [31:0] tpc_ff;
  logic nxt_take, nxt_halt;
  logic [31:0] nxt_tpc;
  logic [31:0] mip;
  logic irq_ok, nmi_vis, irq_vis, exc_any;
  logic trap_take_nmi, trap_take_irq, trap_take_exc;
  logic [10:0] irq_code, exc_code;

  tiu_sync3 #(.W(32)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din(irq_pins),
    .dout(irq_sync)
  );

  tiu_nmi_latch u_nmi (
    .clk(clk),
    .sys_rst(sys_rst),
    .dresp(dresp),
    .nmi_taken(trap_take_nmi),
    .pending(nmi_pend),
    .is_store(nmi_store)
  );

  // Highest pending line by the fixed order; timer line comes last
  function automatic logic [10:0] pick_irq(input logic [31:0] p);
    logic [10:0] c;
    c = TIU_CODE_MTI;
    if (p[TIU_IRQ_MSI]) c = TIU_CODE_MSI;
    if (p[TIU_IRQ_MEI]) c = TIU_CODE_MEI;
    for (int i = TIU_FAST_LO; i <= TIU_FAST_HI; i++)
    begin
      if (p[i]) c = 11'(i);
    end
    return c;
  endfunction : pick_irq

  // Level view, no edge memory; advanced mode drops the lines entirely
  assign mip = ADV_MODE ? 32'h0000_0000 : (irq_sync & TIU_IRQ_VALID_MASK);
  assign irq_ok = mstatus_ff[TIU_MSTATUS_MIE] && !core.debug_mode;
  assign irq_vis = irq_ok && |(mip & mie_ff);
  assign irq_code = pick_irq(mip & mie_ff);
  // NMI ignores the global enable, only debug and stepping hide it
  assign nmi_vis = nmi_pend && !core.debug_mode &&
                   !(core.single_step && !dcsr_ff[TIU_DCSR_STEP_INTERRUPT_ENABLE]);

  always_comb
  begin
    exc_any = exc.valid && (exc.instr_access || exc.instr_bus || exc.illegal ||
              exc.ecall || exc.ebreak || exc.store_access || exc.load_access);
    exc_code = TIU_EXC_LOAD_ACCESS;
    if (exc.store_access) exc_code = TIU_EXC_STORE_ACCESS;
    if (exc.ebreak) exc_code = TIU_EXC_BREAK;
    if (exc.ecall) exc_code = TIU_EXC_ECALL;
    if (exc.illegal) exc_code = TIU_EXC_ILLEGAL;
    if (exc.instr_bus) exc_code = TIU_EXC_INSTR_BUS;
    if (exc.instr_access) exc_code = TIU_EXC_INSTR_ACCESS;
  end

  // Exceptions are precise and win over pending interrupts in the slot
  assign trap_take_exc = trap_slot && exc_any;
  assign trap_take_nmi = trap_slot && !exc_any && nmi_vis;
  assign trap_take_irq = trap_slot && !exc_any && !nmi_vis && irq_vis;

  // AXI4-Lite write path: address and data may arrive in either order
  logic aw_ff, w_ff, bv_ff, rv_ff, arr_ff;
  logic [7:0] awa_ff;
  logic [31:0] wd_ff, rd_ff;
  logic [3:0] ws_ff;
  logic [1:0] br_ff, rr_ff;
  logic nxt_aw, nxt_w, nxt_bv, nxt_rv;
  logic [7:0] nxt_awa;
  logic [31:0] nxt_wd, nxt_rd;
  logic [3:0] nxt_ws;
  logic [1:0] nxt_br, nxt_rr;
  logic wr_go;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++)
    begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction : merge

  assign wr_go = aw_ff && w_ff && !bv_ff;

  always_comb
  begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awa = awa_ff;
    nxt_wd = wd_ff;
    nxt_ws = ws_ff;
    nxt_bv = bv_ff;
    nxt_br = br_ff;
    nxt_rv = rv_ff;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (s_axi_awvalid && s_axi_awready)
    begin
      nxt_aw = 1'b1;
      nxt_awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      nxt_w = 1'b1;
      nxt_wd = s_axi_wdata;
      nxt_ws = s_axi_wstrb;
    end
    if (wr_go)
    begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bv = 1'b1;
      nxt_br = TIU_RESP_OKAY;
      unique case (awa_ff)
        TIU_OFS_MSTATUS, TIU_OFS_MIE, TIU_OFS_MTVEC, TIU_OFS_MEPC, TIU_OFS_MCAUSE,
        TIU_OFS_MIP, TIU_OFS_TRAPPC: nxt_br = TIU_RESP_OKAY;
        TIU_OFS_DCSR: nxt_br = core.debug_mode ? TIU_RESP_OKAY : TIU_RESP_SLVERR;
        default: nxt_br = TIU_RESP_SLVERR;
      endcase
    end
    if (bv_ff && s_axi_bready) nxt_bv = 1'b0;
    if (s_axi_arvalid && arr_ff)
    begin
      nxt_rv = 1'b1;
      nxt_rr = TIU_RESP_OKAY;
      unique case (s_axi_araddr)
        TIU_OFS_MSTATUS: nxt_rd = mstatus_ff;
        TIU_OFS_MIE: nxt_rd = mie_ff;
        TIU_OFS_MIP: nxt_rd = mip;
        TIU_OFS_MTVEC: nxt_rd = mtvec_ff;
        TIU_OFS_MEPC: nxt_rd = mepc_ff;
        TIU_OFS_MCAUSE: nxt_rd = mcause_ff;
        TIU_OFS_TRAPPC: nxt_rd = tpc_ff;
        TIU_OFS_DCSR:
        begin
          nxt_rd = core.debug_mode ? dcsr_ff : 32'h0000_0000;
          nxt_rr = core.debug_mode ? TIU_RESP_OKAY : TIU_RESP_SLVERR;
        end
        default:
        begin
          nxt_rd = 32'h0000_0000;
          nxt_rr = TIU_RESP_SLVERR;
        end
      endcase
    end
    else if (rv_ff && s_axi_rready)
    begin
      nxt_rv = 1'b0;
    end
  end

  // Trap CSR state; hardware updates on entry override software writes
  always_comb
  begin
    nxt_mstatus = mstatus_ff;
    nxt_mie = mie_ff;
    nxt_mtvec = mtvec_ff;
    nxt_mepc = mepc_ff;
    nxt_mcause = mcause_ff;
    nxt_dcsr = dcsr_ff;
    if (wr_go)
    begin
      unique case (awa_ff)
        TIU_OFS_MSTATUS: nxt_mstatus = merge(mstatus_ff, wd_ff, ws_ff);
        TIU_OFS_MIE: nxt_mie = merge(mie_ff, wd_ff, ws_ff) & TIU_IRQ_VALID_MASK;
        TIU_OFS_MTVEC: nxt_mtvec = merge(mtvec_ff, wd_ff, ws_ff);
        TIU_OFS_MEPC: nxt_mepc = merge(mepc_ff, wd_ff, ws_ff);
        TIU_OFS_MCAUSE: nxt_mcause = merge(mcause_ff, wd_ff, ws_ff);
        TIU_OFS_DCSR: if (core.debug_mode) nxt_dcsr = merge(dcsr_ff, wd_ff, ws_ff);
        default: nxt_mstatus = mstatus_ff;
      endcase
    end
    nxt_dcsr[TIU_DCSR_NMIP] = nmi_pend;
    if (core.mret)
    begin
      nxt_mstatus[TIU_MSTATUS_MIE] = mstatus_ff[TIU_MSTATUS_MPIE];
    end
    if (trap_take_exc || trap_take_nmi || trap_take_irq)
    begin
      nxt_mepc = core.pc;
      nxt_mstatus[TIU_MSTATUS_MPIE] = mstatus_ff[TIU_MSTATUS_MIE];
      nxt_mstatus[TIU_MSTATUS_MIE] = 1'b0;
      nxt_mcause = '0;
      if (trap_take_exc)
      begin
        nxt_mcause[10:0] = exc_code;
      end
      else
      begin
        nxt_mcause[TIU_CAUSE_IRQ_BIT] = 1'b1;
        nxt_mcause[10:0] = trap_take_nmi ?
          (nmi_store ? TIU_CODE_NMI_STORE : TIU_CODE_NMI_LOAD) : irq_code;
      end
    end
  end

  always_comb
  begin
    nxt_take = trap_take_exc || trap_take_nmi || trap_take_irq;
    nxt_halt = nmi_vis || irq_vis;
    nxt_tpc = mtvec_ff & TIU_MTVEC_BASE_MASK;
    if (trap_take_irq && mtvec_ff[0])
    begin
      nxt_tpc = (mtvec_ff & TIU_MTVEC_BASE_MASK) + {19'h00000, irq_code, 2'h0};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      mstatus_ff <= TIU_RST_MSTATUS;
      mie_ff <= TIU_RST_MIE;
      mtvec_ff <= TIU_RST_MTVEC;
      mepc_ff <= '0;
      mcause_ff <= '0;
      dcsr_ff <= '0;
      take_ff <= 1'b0;
      halt_ff <= 1'b0;
      tpc_ff <= '0;
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
      bv_ff <= 1'b0;
      br_ff <= '0;
      rv_ff <= 1'b0;
      rd_ff <= '0;
      rr_ff <= '0;
      arr_ff <= 1'b0;
    end
    else
    begin
      mstatus_ff <= nxt_mstatus;
      mie_ff <= nxt_mie;
      mtvec_ff <= nxt_mtvec;
      mepc_ff <= nxt_mepc;
      mcause_ff <= nxt_mcause;
      dcsr_ff <= nxt_dcsr;
      take_ff <= nxt_take;
      halt_ff <= nxt_halt;
      tpc_ff <= nxt_tpc;
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      ws_ff <= nxt_ws;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
      arr_ff <= !nxt_rv && !(s_axi_arvalid && arr_ff);
    end
  end

  // Ready flags are registered so that every output leaves a flop
  logic awr_ff, wr_ff;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      awr_ff <= 1'b0;
      wr_ff <= 1'b0;
    end
    else
    begin
      awr_ff <= !nxt_aw && !(s_axi_awvalid && awr_ff) && !nxt_bv;
      wr_ff <= !nxt_w && !(s_axi_wvalid && wr_ff) && !nxt_bv;
    end
  end

  assign s_axi_awready = awr_ff;
  assign s_axi_wready = wr_ff;
  assign s_axi_bvalid = bv_ff;
  assign s_axi_bresp = br_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_rvalid = rv_ff;
  assign s_axi_rdata = rd_ff;
  assign s_axi_rresp = rr_ff;
  assign trap_take = take_ff;
  assign trap_pc = tpc_ff;
  assign halt_issue = halt_ff;

  a_irq_needs_enable: assert property (@(posedge clk) disable iff (sys_rst)
    trap_take_irq |-> mstatus_ff[TIU_MSTATUS_MIE] && |(mip & mie_ff))
    else $error("interrupt taken while disabled");
  a_debug_no_trap: assert property (@(posedge clk) disable iff (sys_rst)
    core.debug_mode |-> !trap_take_irq && !trap_take_nmi)
    else $error("interrupt taken in debug mode");
  a_nmi_cause_code: assert property (@(posedge clk) disable iff (sys_rst)
    trap_take_nmi |=> mcause_ff[TIU_CAUSE_IRQ_BIT] && mcause_ff[10:1] == 10'h200)
    else $error("nmi cause wrong");
  a_entry_clears_mie: assert property (@(posedge clk) disable iff (sys_rst)
    nxt_take |=> !mstatus_ff[TIU_MSTATUS_MIE] &&
    mstatus_ff[TIU_MSTATUS_MPIE] == $past(mstatus_ff[TIU_MSTATUS_MIE]))
    else $error("entry did not save and clear enable");
  a_nmi_ignores_mie: assert property (@(posedge clk) disable iff (sys_rst)
    nmi_pend && trap_slot && !exc_any && !core.debug_mode && !core.single_step
    |-> trap_take_nmi)
    else $error("nmi masked by global enable");
  a_nmip_tracks: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 dcsr_ff[TIU_DCSR_NMIP] == $past(nmi_pend))
    else $error("nmi pending bit mismatch");
  a_halt_follows: assert property (@(posedge clk) disable iff (sys_rst)
    nmi_vis |=> halt_issue)
    else $error("issue not halted");
  a_exc_wins: assert property (@(posedge clk) disable iff (sys_rst)
    trap_slot && exc.valid && exc.instr_access |=> mcause_ff == 32'h0000_0001)
    else $error("exception priority wrong");
  c_irq_taken: cover property (@(posedge clk) trap_take_irq);
  c_nmi_taken: cover property (@(posedge clk) trap_take_nmi && nmi_store);
  c_exc_taken: cover property (@(posedge clk) trap_take_exc);
endmodule : tiu_trap_unit
